/* File: test/dci_ctl_model.sv */
// controller model: link clock, clock gate, command pins and write strobe
// assumes one caller at a time; link clock runs free, unrelated to clk_i
`timescale 1ns/1ps
`default_nettype none
module dci_ctl_model (
   input wire logic clk_i,
   output logic ck_o,
   output logic ck_n_o,
   output logic cke_o,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [2:0] ba_o,
   output logic [15:0] a_o,
   output logic dqs_o,
   output logic [7:0] dq_o
);
   // --------
   // link clock
   // --------
   assign ck_n_o = ~ck_o;
   initial begin
      ck_o = 1'b0;
      cke_o = 1'b1;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
      ba_o = 3'h0;
      a_o = 16'h0000;
      dqs_o = 1'b0;
      dq_o = 8'h00;
      #130;
      forever #400 ck_o = ~ck_o;
   end
   // --------
   // pin tasks
   // --------
   // refresh pacing is left to the caller; a run is far shorter than one window
   // pins change at the fall, so they stand half a period either side of the rise
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
         input logic k);
      @(negedge ck_o);
      @(posedge clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
      ba_o <= b;
      a_o <= a;
      cke_o <= k;
      @(posedge ck_o);
      @(negedge ck_o);
      @(posedge clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h7;
      ba_o <= ~b;
      a_o <= ~a;
      #1;
   endtask
   // command shown only during the low phase, gone well before the rise
   task automatic glitch(input logic [3:0] c, input logic [2:0] b);
      @(negedge ck_o);
      @(posedge clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
      ba_o <= b;
      repeat (3) @(posedge clk_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h7;
      @(posedge ck_o);
      @(negedge ck_o);
      #1;
   endtask
   task automatic wdata(input logic [63:0] d);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         dq_o <= d[8*i +: 8];
         repeat (3) @(posedge clk_i);
         dqs_o <= ~dqs_o;
         repeat (3) @(posedge clk_i);
      end
      dq_o <= ~d[63:56];
   endtask
endmodule // dci_ctl_model
`default_nettype wire

/* File: test/test_ddr3_dram_cmd_addr_interface.sv */
// self-checking bench for the command/address front end
// assumes dci_ctl_model drives the pins and the write strobe
`timescale 1ns/1ps
`default_nettype none
module test_ddr3_dram_cmd_addr_interface;
   // --------
   // pins
   // --------
   localparam logic [63:0] W = 64'h8877665544332211;
   logic clk, rst, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, dqs;
   logic dq_oe, rdqs, rdqs_n, dqs_oe, pdn, sref, refr;
   logic [2:0] ba;
   logic [15:0] a;
   logic [15:0] open_row;
   logic [7:0] dq, rdq, bank_open;
   int errors, num_checks, refs, ck_rises;
   wire logic [7:0] dqw = dq_oe ? rdq : dq;
   wire logic dqsw = dqs_oe ? rdqs : dqs;
   dci_ctl_model ctl (.clk_i(clk), .ck_o(ck), .ck_n_o(ck_n), .cke_o(cke), .cs_n_o(cs_n),
      .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .a_o(a), .dqs_o(dqs),
      .dq_o(dq));
   dci_front uut (.CLOCK_I(clk), .RST_I(rst), .CK_I(ck), .CK_N_I(ck_n), .CKE_I(cke),
      .CS_N_I(cs_n), .RAS_N_I(ras_n), .CAS_N_I(cas_n), .WE_N_I(we_n), .BANK_SELECT_I(ba),
      .ADDR_I(a), .DQS_I(dqsw), .DQ_I(dqw), .DQ_O(rdq), .DQ_OE_O(dq_oe), .DQS_O(rdqs),
      .DQS_N_O(rdqs_n), .DQS_OE_O(dqs_oe), .BANK_OPEN_O(bank_open), .OPEN_ROW_O(open_row),
      .POWER_DOWN_O(pdn), .SELF_REFRESH_O(sref), .REFRESH_O(refr));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   end
   always @(posedge clk) if (refr === 1'b1) refs <= refs + 1;
   always @(posedge ck) ck_rises <= ck_rises + 1;
   initial begin
      #1000000;
      errors++;
      summarize();
   end
   // --------
   // helpers
   // --------
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // expected burst from the written word, same indexing as the column order
   function automatic logic [63:0] ord(input logic [2:0] st, input logic il, input logic ch);
      logic [2:0] ix;
      ord = '0;
      for (int i = 0; i < (ch ? 4 : 8); i++) begin
         ix = il ? st ^ 3'(i) : st + 3'(i);
         if (ch) ix = {st[2], ix[1:0]};
         ord[8*i +: 8] = W[8*ix +: 8];
      end
   endfunction
   // latency counted in link rises after the command rise
   task automatic rd(output logic [63:0] got, output int n, output int lat);
      int t0;
      int t;
      logic s;
      got = '0;
      n = 0;
      t = 0;
      s = 1'b0;
      t0 = ck_rises;
      while (dq_oe !== 1'b1 && t < 300) begin
         @(posedge clk);
         #1;
         t++;
      end
      lat = ck_rises - t0;
      while (dq_oe === 1'b1 && t < 600) begin
         if (n == 0 || rdqs !== s) begin
            chk({dqs_oe, rdqs_n ^ rdqs}, 64'h3);
            if (n < 8) got[8*n +: 8] = rdq;
            n++;
            s = rdqs;
         end
         @(posedge clk);
         #1;
         t++;
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [63:0] e, input int en,
         input int el);
      logic [63:0] got;
      int n;
      int lat;
      ctl.cmd(dci_pkg::CMD_RD, 3'h2, a, 1'b1);
      rd(got, n, lat);
      chk(got, e);
      chk(64'(n), 64'(en));
      chk(64'(lat), 64'(el));
   endtask
   // --------
   // tests
   // --------
   initial begin
      logic [63:0] g;
      int n;
      int l;
      errors = 0;
      num_checks = 0;
      refs = 0;
      ck_rises = 0;
      @(negedge rst);
      repeat (3) @(posedge ck);
      ctl.cmd(4'hB, 3'h1, 16'h0000, 1'b1);
      chk(bank_open, 8'h00);
      ctl.glitch(dci_pkg::CMD_ACT, 3'h7);
      chk(bank_open, 8'h00);
      ctl.cmd(dci_pkg::CMD_ACT, 3'h2, 16'hBEEF, 1'b1);
      ctl.cmd(dci_pkg::CMD_ACT, 3'h6, 16'h1234, 1'b1);
      chk(bank_open, 8'h44);
      ctl.cmd(dci_pkg::CMD_REF, 3'h0, 16'h0000, 1'b1);
      chk(64'(refs), 64'h0);
      ctl.cmd(dci_pkg::CMD_WR, 3'h2, 16'h1000, 1'b1);
      ctl.wdata(W);
      rdchk(16'h1803, ord(3'h3, 1'b0, 1'b0), 8, 5);
      chk(open_row, 16'hBEEF);
      ctl.cmd(dci_pkg::CMD_MRS, 3'h0, 16'h0008, 1'b1);
      rdchk(16'h1005, ord(3'h5, 1'b1, 1'b0), 8, 5);
      ctl.cmd(dci_pkg::CMD_MRS, 3'h0, 16'h0011, 1'b1);
      rdchk(16'h0006, ord(3'h6, 1'b0, 1'b1), 4, 6);
      rdchk(16'h1006, ord(3'h6, 1'b0, 1'b0), 8, 6);
      ctl.cmd(dci_pkg::CMD_MRS, 3'h0, 16'h0000, 1'b1);
      for (int k = 2; k >= 0; k--) begin
         ctl.cmd(dci_pkg::CMD_MRS, 3'h1, 16'(k << 3), 1'b1);
         rdchk(16'h1000, W, 8, (k == 0) ? 5 : 10 - k);
      end
      ctl.cmd(dci_pkg::CMD_RD, 3'h6, 16'h1400, 1'b1);
      rd(g, n, l);
      chk(open_row, 16'h1234);
      chk(bank_open, 8'h04);
      ctl.cmd(dci_pkg::CMD_ACT, 3'h6, 16'h0042, 1'b1);
      ctl.cmd(dci_pkg::CMD_PRE, 3'h6, 16'h0000, 1'b1);
      chk(bank_open, 8'h04);
      ctl.cmd(dci_pkg::CMD_ACT, 3'h6, 16'h0042, 1'b1);
      ctl.cmd(dci_pkg::CMD_PRE, 3'h0, 16'h0400, 1'b1);
      chk(bank_open, 8'h00);
      ctl.cmd(dci_pkg::CMD_REF, 3'h0, 16'h0000, 1'b1);
      chk(64'(refs), 64'h1);
      ctl.cmd(4'h7, 3'h0, 16'h0000, 1'b0);
      chk({sref, pdn}, 2'b01);
      ctl.cmd(4'h7, 3'h0, 16'h0000, 1'b1);
      chk({sref, pdn}, 2'b00);
      ctl.cmd(dci_pkg::CMD_REF, 3'h0, 16'h0000, 1'b0);
      chk({sref, pdn}, 2'b10);
      ctl.cmd(4'h7, 3'h0, 16'h0000, 1'b1);
      chk({sref, pdn}, 2'b00);
      ctl.cmd(dci_pkg::CMD_ACT, 3'h3, 16'h0001, 1'b1);
      ctl.cmd(4'h7, 3'h0, 16'h0000, 1'b0);
      ctl.cmd(dci_pkg::CMD_ACT, 3'h4, 16'h0001, 1'b0);
      chk({pdn, bank_open}, 9'h008);
      ctl.cmd(4'h7, 3'h0, 16'h0000, 1'b1);
      summarize();
   end
endmodule // test_ddr3_dram_cmd_addr_interface
`default_nettype wire

/* File: verilog/dci_col_mem.sv */
// column store: one prefetch word of eight bytes per bank and column group
// assumes one write port and one read port, read data registered
`timescale 1ns/1ps
`default_nettype none
module dci_col_mem (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [dci_pkg::MEM_AW-1:0] wr_addr_i,
   input wire logic [dci_pkg::MEM_DW-1:0] wr_data_i,
   input wire logic [dci_pkg::MEM_AW-1:0] rd_addr_i,
   output logic [dci_pkg::MEM_DW-1:0] rd_data_o
);
   // ---------------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [dci_pkg::MEM_DW-1:0] rd_data;
   } dci_mem_s;

   // the array stays outside the state record: it is not reset
   logic [dci_pkg::MEM_DW-1:0] mem [0:(1 << dci_pkg::MEM_AW)-1];
   dci_mem_s q, d;

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_comb begin
      d = q;
      d.rd_data = mem[rd_addr_i];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rd_data_o = q.rd_data;
endmodule // dci_col_mem
`default_nettype wire

/* File: verilog/dci_front.sv */
// command, address and clock-gate front end of an eight-bank ddr3 memory
// assumes pins are asynchronous to CLOCK_I and the link clock is much slower
// Notes on behaviour
// (R1) command, address and gate inputs are taken only where true clock rises and complement falls
// (R2) read words leave on both crossing directions, one per half period
// (R3) clock gate low freezes state, outputs and burst position next cycle
// (R4) gate drop with all banks idle enters power-down or self-refresh
// (R5) three bank-select bits pick one of eight banks per command
// (R6) activate stores all sixteen address bits as the bank row
// (R7) read and write use address bits nine to zero as column
// (R8) mode register set loads address bits into the selected mode register
// (R9) burst of four or eight, sequential or interleaved order
// (R10) added latency zero, CAS latency minus one or minus two delays execution
// (R11) controller refreshes 8192 times per 64 ms, 7.8us or 3.9us average; the controller model leaves refresh pacing to its caller
// (R12) data strobe times data: device drives on reads, controller on writes
// (R13) each column access moves eight words per data pin at once
// (R14) bit ten: auto precharge on read/write, all banks on precharge
// (R15) bit twelve low chops an on-the-fly burst to four
// (R16) select high masks every command
// (R17) row/column/write strobes decode activate, precharge, read and write
`timescale 1ns/1ps
`default_nettype none
module dci_front (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CK_I,
   input wire logic CK_N_I,
   input wire logic CKE_I,
   input wire logic CS_N_I,
   input wire logic RAS_N_I,
   input wire logic CAS_N_I,
   input wire logic WE_N_I,
   input wire logic [2:0] BANK_SELECT_I,
   input wire logic [15:0] ADDR_I,
   input wire logic DQS_I,
   input wire logic [7:0] DQ_I,
   output logic [7:0] DQ_O,
   output logic DQ_OE_O,
   output logic DQS_O,
   output logic DQS_N_O,
   output logic DQS_OE_O,
   output logic [7:0] BANK_OPEN_O,
   output logic [15:0] OPEN_ROW_O,
   output logic POWER_DOWN_O,
   output logic SELF_REFRESH_O,
   output logic REFRESH_O
);
   // ---------------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic [dci_pkg::PIN_W-1:0] s1;
      logic [dci_pkg::PIN_W-1:0] s2;
      logic [dci_pkg::PIN_W-1:0] s3;
      logic cke_live;
      dci_pkg::dci_state_e st;
      logic [dci_pkg::BANKS-1:0] bank_open;
      logic [dci_pkg::BANKS-1:0][dci_pkg::A_W-1:0] rows;
      logic [dci_pkg::MR_N-1:0][dci_pkg::A_W-1:0] mr;
      logic [dci_pkg::BA_W-1:0] bank;
      logic [dci_pkg::COL_W-1:0] col;
      logic rd;
      logic ap;
      logic [3:0] bl;
      logic [3:0] cnt;
      logic [3:0] word;
      logic [dci_pkg::BURST_MAX-1:0][dci_pkg::DQ_W-1:0] wbuf;
      logic [dci_pkg::DQ_W-1:0] dq;
      logic dq_oe;
      logic dqs;
      logic dqs_n;
      logic dqs_oe;
      logic pd;
      logic sr;
      logic refresh;
      logic [dci_pkg::A_W-1:0] open_row;
      logic mem_we;
   } dci_front_s;
   dci_front_s q, d;
   logic [dci_pkg::MEM_DW-1:0] rd_data;
   logic [dci_pkg::PIN_W-1:0] pins;
   logic cross_x, fall_x, half_x, tick, dqs_edge, cke_s, ap_s, bc_s, idle_go, enter_lp, bt;
   logic [dci_pkg::CMD_W-1:0] cmd;
   logic [dci_pkg::BA_W-1:0] ba;
   logic [dci_pkg::A_W-1:0] addr;
   logic [dci_pkg::DQ_W-1:0] dq_s;
   logic [3:0] cl, al;
   logic [1:0] bl_mode, al_mode;
   // burst position to byte lane of the prefetch word
   function automatic logic [2:0] order_idx(input logic [2:0] st, input logic [2:0] i,
                                            input logic inter, input logic chop);
      logic [1:0] low;
      low = inter ? (st[1:0] ^ i[1:0]) : 2'(st[1:0] + i[1:0]);
      return chop ? {st[2], low} : (inter ? (st ^ i) : 3'(st + i));
   endfunction
   // ---------------------------------------------------------------------
   // pin sampling and crossing detection
   // ---------------------------------------------------------------------
   assign pins = {CK_I, CK_N_I, CKE_I, CS_N_I, RAS_N_I, CAS_N_I, WE_N_I,
                  BANK_SELECT_I, ADDR_I, DQS_I, DQ_I};
   // true rising while complement falls, seen in the same sample
   assign cross_x = q.s2[dci_pkg::P_CK] & ~q.s3[dci_pkg::P_CK] &
                    ~q.s2[dci_pkg::P_CKN] & q.s3[dci_pkg::P_CKN]; // R1
   assign fall_x = ~q.s2[dci_pkg::P_CK] & q.s3[dci_pkg::P_CK];
   assign half_x = (cross_x | fall_x) & q.cke_live; // R2 R3
   assign tick = cross_x & q.cke_live; // R3
   assign dqs_edge = (q.s2[dci_pkg::P_DQS] ^ q.s3[dci_pkg::P_DQS]) & q.cke_live; // R12
   assign cke_s = q.s2[dci_pkg::P_CKE];
   assign cmd = q.s2[dci_pkg::P_CMD_LO +: dci_pkg::CMD_W]; // R16 R17
   assign ba = q.s2[dci_pkg::P_BA_LO +: dci_pkg::BA_W]; // R5
   assign addr = q.s2[dci_pkg::P_A_LO +: dci_pkg::A_W];
   assign dq_s = q.s2[dci_pkg::P_DQ_LO +: dci_pkg::DQ_W];
   assign ap_s = addr[dci_pkg::A_AP];
   assign bc_s = addr[dci_pkg::A_BC];
   assign idle_go = tick && (q.st == dci_pkg::ST_IDLE);
   assign enter_lp = idle_go && !cke_s && (q.bank_open == '0); // R4
   // ---------------------------------------------------------------------
   // mode register fields
   // ---------------------------------------------------------------------
   assign bl_mode = q.mr[0][dci_pkg::MR0_BL_LO +: 2];
   assign bt = q.mr[0][dci_pkg::MR0_BT];
   assign cl = 4'(q.mr[0][dci_pkg::MR0_CL_LO +: dci_pkg::MR0_CL_W]) + dci_pkg::CL_BASE;
   assign al_mode = q.mr[1][dci_pkg::MR1_AL_LO +: 2];
   assign al = (al_mode == dci_pkg::AL_CL1) ? cl - dci_pkg::ONE4 :
               (al_mode == dci_pkg::AL_CL2) ? cl - dci_pkg::TWO4 : dci_pkg::ZERO4; // R10
   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   always_comb begin
      logic exec;
      logic [2:0] idx;
      exec = 1'b0;
      idx = order_idx(q.col[2:0], q.word[2:0], bt, q.bl == dci_pkg::LEN4);
      d = q;
      // first stage feeds only the second
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.refresh = 1'b0;
      d.mem_we = 1'b0;
      d.cke_live = cross_x ? cke_s : q.cke_live; // R3
      case (q.st)
         dci_pkg::ST_IDLE: begin
            if (enter_lp) begin // R4
               if (cmd == dci_pkg::CMD_REF) begin
                  d.st = dci_pkg::ST_SELF_REFRESH;
                  d.sr = 1'b1;
               end else begin
                  d.st = dci_pkg::ST_POWER_DOWN;
                  d.pd = 1'b1;
               end
            end else if (idle_go) begin
               case (cmd) // R16 R17
                  dci_pkg::CMD_ACT: begin
                     d.bank_open[ba] = 1'b1; // R5
                     d.rows[ba] = addr; // R6
                  end
                  dci_pkg::CMD_PRE: begin
                     if (ap_s) begin
                        d.bank_open = '0; // R14
                     end else begin
                        d.bank_open[ba] = 1'b0; // R5 R14
                     end
                  end
                  dci_pkg::CMD_REF: begin
                     d.refresh = (q.bank_open == '0);
                  end
                  dci_pkg::CMD_MRS: begin
                     d.mr[ba[dci_pkg::MR_SEL_W-1:0]] = addr; // R8
                  end
                  dci_pkg::CMD_RD, dci_pkg::CMD_WR: begin
                     if (q.bank_open[ba]) begin
                        d.bank = ba; // R5
                        d.col = addr[dci_pkg::COL_W-1:0]; // R7
                        d.rd = (cmd == dci_pkg::CMD_RD);
                        d.ap = ap_s; // R14
                        d.open_row = q.rows[ba];
                        // R9 R15
                        if (bl_mode == dci_pkg::BL_FIX4 || (bl_mode == dci_pkg::BL_OTF && !bc_s)) begin
                           d.bl = dci_pkg::LEN4;
                        end else begin
                           d.bl = dci_pkg::LEN8;
                        end
                        if (al == dci_pkg::ZERO4) begin
                           exec = 1'b1;
                        end else begin
                           d.st = dci_pkg::ST_AL_WAIT; // R10
                           d.cnt = al - dci_pkg::ONE4;
                        end
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         dci_pkg::ST_AL_WAIT: begin
            if (tick) begin // R10
               if (q.cnt == dci_pkg::ZERO4) begin
                  exec = 1'b1;
               end else begin
                  d.cnt = q.cnt - dci_pkg::ONE4;
               end
            end
         end
         dci_pkg::ST_CL_WAIT: begin
            if (tick) begin
               if (q.cnt == dci_pkg::ZERO4) begin
                  d.st = dci_pkg::ST_READ;
                  d.dq = rd_data[dci_pkg::DQ_W * idx +: dci_pkg::DQ_W]; // R13
                  d.dq_oe = 1'b1;
                  d.dqs = 1'b1; // R12
                  d.dqs_n = 1'b0;
                  d.dqs_oe = 1'b1;
                  d.word = dci_pkg::ONE4;
               end else begin
                  d.cnt = q.cnt - dci_pkg::ONE4;
               end
            end
         end
         dci_pkg::ST_READ: begin
            if (half_x) begin // R2
               if (q.word == q.bl) begin
                  d.st = dci_pkg::ST_IDLE;
                  d.dq_oe = 1'b0;
                  d.dqs_oe = 1'b0;
                  if (q.ap) begin
                     d.bank_open[q.bank] = 1'b0; // R14
                  end
               end else begin
                  d.dq = rd_data[dci_pkg::DQ_W * idx +: dci_pkg::DQ_W];
                  d.dqs = ~q.dqs; // R12
                  d.dqs_n = q.dqs;
                  d.word = q.word + dci_pkg::ONE4;
               end
            end
         end
         dci_pkg::ST_WRITE: begin
            if (dqs_edge) begin // R12
               d.wbuf[idx] = dq_s;
               if (q.word == q.bl - dci_pkg::ONE4) begin
                  d.st = dci_pkg::ST_IDLE;
                  d.mem_we = 1'b1; // R13
                  if (q.ap) begin
                     d.bank_open[q.bank] = 1'b0; // R14
                  end
               end else begin
                  d.word = q.word + dci_pkg::ONE4;
               end
            end
         end
         dci_pkg::ST_POWER_DOWN, dci_pkg::ST_SELF_REFRESH: begin
            if (cross_x && cke_s) begin
               d.st = dci_pkg::ST_IDLE;
               d.pd = 1'b0;
               d.sr = 1'b0;
            end
         end
         default: begin
            d.st = dci_pkg::ST_IDLE;
         end
      endcase
      if (exec) begin
         d.word = dci_pkg::ZERO4;
         if (d.rd) begin
            d.st = dci_pkg::ST_CL_WAIT;
            d.cnt = cl - dci_pkg::ONE4;
         end else begin
            d.st = dci_pkg::ST_WRITE;
         end
      end
   end
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   // ---------------------------------------------------------------------
   // column store
   // ---------------------------------------------------------------------
   // one prefetch word per column group; low column bits only order the burst
   dci_col_mem u_mem (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .wr_en_i(q.mem_we),
      .wr_addr_i({q.bank, q.col[dci_pkg::COL_W-1:dci_pkg::COL_ORD_W]}),
      .wr_data_i(q.wbuf),
      .rd_addr_i({q.bank, q.col[dci_pkg::COL_W-1:dci_pkg::COL_ORD_W]}),
      .rd_data_o(rd_data)
   );
   assign {DQ_O, DQ_OE_O, DQS_O, DQS_N_O, DQS_OE_O} = {q.dq, q.dq_oe, q.dqs, q.dqs_n, q.dqs_oe};
   assign {BANK_OPEN_O, OPEN_ROW_O} = {q.bank_open, q.open_row};
   assign {POWER_DOWN_O, SELF_REFRESH_O, REFRESH_O} = {q.pd, q.sr, q.refresh};
   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);
   logic act_go, pre_all_go, rw_go, mrs_go;
   assign act_go = idle_go && !enter_lp && cmd == dci_pkg::CMD_ACT;
   assign pre_all_go = idle_go && !enter_lp && cmd == dci_pkg::CMD_PRE && ap_s;
   assign mrs_go = idle_go && !enter_lp && cmd == dci_pkg::CMD_MRS;
   assign rw_go = idle_go && !enter_lp && q.bank_open[ba] &&
                  (cmd == dci_pkg::CMD_RD || cmd == dci_pkg::CMD_WR);
   chk_open_at_cross: assert property ($changed(q.bank_open) && !$past(q.mem_we) |-> // R1
      $past(cross_x) || $past(half_x) || $past(dqs_edge)) else $error("bank state moved off a crossing");
   chk_read_half_edges: assert property (q.dq_oe && $changed(q.dq) |-> $past(half_x) || $past(tick)) // R2
      else $error("read word changed off a clock crossing");
   chk_gate_freeze: assert property (!q.cke_live && q.st != dci_pkg::ST_POWER_DOWN && // R3
      q.st != dci_pkg::ST_SELF_REFRESH |=> $stable(q.word) && $stable(q.dq) && $stable(q.st))
      else $error("state moved while clock gate low");
   chk_lowpower_idle: assert property ($rose(q.pd) || $rose(q.sr) |-> $past(q.bank_open) == '0) // R4
      else $error("low power entered with a bank open");
   chk_act_row: assert property (act_go |=> q.bank_open[$past(ba)] && q.rows[$past(ba)] == $past(addr)) // R5 R6
      else $error("activate did not open bank with its row");
   chk_col_take: assert property (rw_go |=> q.col == $past(addr[dci_pkg::COL_W-1:0]) && q.bank == $past(ba)) // R7
      else $error("column or bank not taken from address");
   chk_mrs_load: assert property (mrs_go |=> q.mr[$past(ba[1:0])] == $past(addr)) // R8
      else $error("mode register not loaded");
   chk_burst_len: assert property (rw_go && bl_mode == dci_pkg::BL_OTF |=> // R9 R15
      q.bl == ($past(bc_s) ? dci_pkg::LEN8 : dci_pkg::LEN4)) else $error("wrong burst length");
   chk_pre_all: assert property (pre_all_go |=> q.bank_open == '0) // R14
      else $error("precharge all left a bank open");
   chk_select_mask: assert property (cross_x && cmd[dci_pkg::CMD_W-1] && !enter_lp && // R16
      q.st == dci_pkg::ST_IDLE |=> $stable(q.bank_open) && $stable(q.mr) && q.st == dci_pkg::ST_IDLE)
      else $error("masked command had an effect");
   chk_al_delay: assert property (rw_go && al == dci_pkg::ZERO4 |=> q.st != dci_pkg::ST_AL_WAIT) // R10
      else $error("zero added latency still waited");
   cov_read_burst: cover property ($fell(q.dq_oe));
   cov_write_store: cover property (q.mem_we);
   cov_self_refresh: cover property ($rose(q.sr));
   cov_power_down: cover property ($rose(q.pd));
endmodule // dci_front
`default_nettype wire

/* File: verilog/dci_pkg.sv */
// constants, field layouts and state names for the command/address front end
// assumes every consumer refers to names as dci_pkg::name, nothing imported
package dci_pkg;
   // ---------------------------------------------------------------------
   // synchronised pin vector layout
   // ---------------------------------------------------------------------
   localparam int PIN_W = 35;
   localparam int P_CK = 34;
   localparam int P_CKN = 33;
   localparam int P_CKE = 32;
   localparam int P_CMD_LO = 28;
   localparam int P_BA_LO = 25;
   localparam int P_A_LO = 9;
   localparam int P_DQS = 8;
   localparam int P_DQ_LO = 0;
   // ---------------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------------
   localparam int BA_W = 3;
   localparam int A_W = 16;
   localparam int DQ_W = 8;
   localparam int CMD_W = 4;
   localparam int COL_W = 10;
   localparam int BURST_MAX = 8;
   localparam int BANKS = 8;
   localparam int MR_N = 4;
   localparam int MEM_AW = 10;
   localparam int MEM_DW = 64;
   localparam int MR_SEL_W = 2;
   // ---------------------------------------------------------------------
   // command codes as {select_n, row_n, col_n, write_n}
   // ---------------------------------------------------------------------
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   // ---------------------------------------------------------------------
   // address bit roles and mode register fields
   // ---------------------------------------------------------------------
   localparam int A_AP = 10;
   localparam int A_BC = 12;
   localparam int COL_ORD_W = 3;
   localparam int MR0_BL_LO = 0;
   localparam int MR0_BT = 3;
   localparam int MR0_CL_LO = 4;
   localparam int MR0_CL_W = 3;
   localparam int MR1_AL_LO = 3;
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;
   localparam logic [1:0] AL_ZERO = 2'h0;
   localparam logic [1:0] AL_CL1 = 2'h1;
   localparam logic [1:0] AL_CL2 = 2'h2;
   localparam logic [3:0] CL_BASE = 4'h5;
   localparam logic [3:0] LEN4 = 4'h4;
   localparam logic [3:0] LEN8 = 4'h8;
   localparam logic [3:0] ONE4 = 4'h1;
   localparam logic [3:0] TWO4 = 4'h2;
   localparam logic [3:0] ZERO4 = 4'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_AL_WAIT,
      ST_CL_WAIT,
      ST_READ,
      ST_WRITE,
      ST_POWER_DOWN,
      ST_SELF_REFRESH
   } dci_state_e;
endpackage
